// *** shared/lsd_pkg.sv ***
/*
  Shared constants for the LED sink driver logic: pin key pattern, timing and reset values.
  Assumes a single 40 MHz system clock and a synchronous active-high reset.
*/
package lsd_pkg;
  localparam int CLK_PERIOD_NS     = 25;     // 40 MHz system clock
  localparam int DETECT_TIME_NS    = 2000;   // Least LED evaluation window
  // Least time, so round up to whole cycles
  localparam int DETECT_CYCLES     = (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHANNELS          = 8;
  localparam int KEY_STEPS         = 5;
  localparam int FIFO_DEPTH        = 32;
  localparam int SYNC_WIDTH        = 4 + CHANNELS;
  // Key history, oldest step first, {enable_n, latch} per step
  localparam logic [9:0] KEY_PATTERN = 10'h22E;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  localparam logic [7:0] TIMER_DONE  = 8'(DETECT_CYCLES);
  localparam logic [2:0] LAST_BIT    = 3'h7;
  localparam logic [7:0] SREG_RESET  = 8'h00;
  localparam logic [7:0] ALL_FAULT   = 8'hFF;

  typedef enum logic [1:0] {
    LSD_NORMAL = 2'b00,
    LSD_DETECT = 2'b01,
    LSD_DRIVE  = 2'b10,
    LSD_RESULT = 2'b11
  } lsd_state_t;
endpackage

// *** rtl/lsd_fifo.sv ***
/*
  Parameterised synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset; read data is shown while outValid.
*/
module lsd_fifo
  import lsd_pkg::*;
#(
  parameter int WIDTH = CHANNELS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic [AW:0]      next_wrPtr;
  logic [AW:0]      next_rdPtr;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit
  always_comb begin
    inReady    = (wrPtr[AW] == rdPtr[AW]) || (wrPtr[AW-1:0] != rdPtr[AW-1:0]);
    outValid   = wrPtr != rdPtr;
    outData    = mem[rdPtr[AW-1:0]];
    push       = inValid && inReady;
    pop        = outValid && outReady;
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
  end

  // Storage array has no reset; only the pointers define content
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
    if (push) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule

// *** rtl/lsd_driver.sv ***
/*
  LED sink driver logic: shift register, storage, output gating and error-detection mode.
  Assumes host pins are asynchronous to clk (40 MHz) and the host shift clock stays
  well below clk so both of its edges are seen after synchronisation.
*/
module lsd_driver
  import lsd_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                shiftClkPin,
  input  wire logic                serial_in,
  input  wire logic                latch_key1_pin,
  input  wire logic                enable_n_key2_pin,
  input  wire logic [CHANNELS-1:0] faultSense,
  output logic                     serial_out,
  output logic      [CHANNELS-1:0] channelOn
);
  logic [SYNC_WIDTH-1:0] syncA;
  logic [SYNC_WIDTH-1:0] syncB;
  logic                  sclkPrev;
  logic                  latchPrev;
  logic                  sclk;
  logic                  serIn;
  logic                  latch;
  logic                  enN;
  logic [CHANNELS-1:0]   faultSync;
  logic                  shiftRise;
  logic                  shiftFall;
  logic                  latchRise;
  logic                  keyMatch;
  logic                  timerDone;
  lsd_state_t            state;
  lsd_state_t            next_state;
  logic [7:0]            sreg;
  logic [7:0]            next_sreg;
  logic [9:0]            keyHist;
  logic [9:0]            next_keyHist;
  logic [7:0]            timer;
  logic [7:0]            next_timer;
  logic [2:0]            bitCnt;
  logic [2:0]            next_bitCnt;
  logic                  next_serialOut;
  logic [7:0]            storage;
  logic [7:0]            next_storage;
  logic [CHANNELS-1:0]   next_channelOn;
  logic                  pushReq;
  logic                  next_pushReq;
  logic [7:0]            latchWord;
  logic [7:0]            next_latchWord;
  logic                  fifoInReady;
  logic                  fifoOutValid;
  logic                  fifoOutReady;
  logic [7:0]            fifoOutData;

  // Two-stage synchronisers; only syncB and later flops are read by logic
  always_ff @(posedge clk) begin
    if (reset) begin
      syncA     <= '0;
      syncB     <= '0;
      sclkPrev  <= 1'b0;
      latchPrev <= 1'b0;
    end else begin
      syncA     <= {faultSense, enable_n_key2_pin, latch_key1_pin, serial_in, shiftClkPin};
      syncB     <= syncA;
      sclkPrev  <= syncB[0];
      latchPrev <= syncB[2];
    end
  end

  // Decoded pin levels and edges
  always_comb begin
    sclk      = syncB[0];
    serIn     = syncB[1];
    latch     = syncB[2];
    enN       = syncB[3];
    faultSync = syncB[SYNC_WIDTH-1:4];
    // Each shift clock phase must span two clk, which caps the usable shift rate below clk / 4
    shiftRise = sclk && !sclkPrev;
    shiftFall = !sclk && sclkPrev;
    latchRise = latch && !latchPrev;
    keyMatch  = {keyHist[7:0], enN, latch} == KEY_PATTERN;
    timerDone = timer == TIMER_DONE;
    fifoOutReady = (state == LSD_NORMAL) || (state == LSD_DETECT);
  end

  // Next-state logic for shifting, key tracking, detection and output gating
  always_comb begin
    next_state     = state;
    next_sreg      = sreg;
    next_keyHist   = keyHist;
    next_timer     = timer;
    next_bitCnt    = bitCnt;
    next_serialOut = serial_out;
    next_storage   = storage;
    next_pushReq   = pushReq && !fifoInReady;
    next_latchWord = latchWord;
    if (shiftRise) begin
      next_sreg    = {sreg[6:0], serIn};
      next_keyHist = {keyHist[7:0], enN, latch};
    end
    if (shiftFall) begin
      next_serialOut = sreg[7];
    end
    // Newest word wins while the FIFO is full, as a transparent latch would
    if (latch && (latchRise || shiftRise)) begin
      next_pushReq   = 1'b1;
      next_latchWord = next_sreg;
    end
    case (state)
      LSD_NORMAL: begin
        if (shiftRise && keyMatch) begin
          next_state   = LSD_DETECT;
          next_keyHist = '0;
        end
      end
      LSD_DETECT: begin
        next_timer = TIMER_RESET;
        if (!enN) begin
          next_state = LSD_DRIVE;
        end
      end
      LSD_DRIVE: begin
        if (!timerDone) begin
          next_timer = timer + 8'h01;
        end
        // An early enable release gives no valid result, so all channels report a fault
        if (enN) begin
          next_sreg   = timerDone ? faultSync : ALL_FAULT;
          next_bitCnt = 3'h0;
          next_state  = LSD_RESULT;
        end
      end
      LSD_RESULT: begin
        if (shiftRise) begin
          // Host clocks rise first, so the first edge holds the status and bit 7 is not lost
          if (bitCnt == 3'h0) begin
            next_sreg = sreg;
          end
          next_bitCnt = bitCnt + 3'h1;
          if (bitCnt == LAST_BIT) begin
            next_state = LSD_NORMAL;
          end
        end
      end
      default: begin
        next_state = LSD_NORMAL;
      end
    endcase
    if (fifoOutValid && fifoOutReady) begin
      next_storage = fifoOutData;
    end
    next_channelOn = enN ? '0 : storage;
  end

  // State registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state      <= LSD_NORMAL;
      sreg       <= SREG_RESET;
      keyHist    <= '0;
      timer      <= TIMER_RESET;
      bitCnt     <= 3'h0;
      serial_out <= 1'b0;
      storage    <= SREG_RESET;
      channelOn  <= '0;
      pushReq    <= 1'b0;
      latchWord  <= SREG_RESET;
    end else begin
      state      <= next_state;
      sreg       <= next_sreg;
      keyHist    <= next_keyHist;
      timer      <= next_timer;
      bitCnt     <= next_bitCnt;
      serial_out <= next_serialOut;
      storage    <= next_storage;
      channelOn  <= next_channelOn;
      pushReq    <= next_pushReq;
      latchWord  <= next_latchWord;
    end
  end

  // Latched words queue here; draining pauses during the detection drive and readout
  lsd_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .reset    (reset),
    .inValid  (pushReq),
    .inReady  (fifoInReady),
    .inData   (latchWord),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  sequence s_driveEnd;
    state == LSD_DRIVE && enN && timerDone;
  endsequence

  sequence s_lastShift;
    state == LSD_RESULT && shiftRise && bitCnt == LAST_BIT;
  endsequence

  AST_SHIFT: assert property (@(posedge clk) disable iff (reset)
    shiftRise && state != LSD_DRIVE && !(state == LSD_RESULT && bitCnt == 3'h0)
      |=> sreg == {$past(sreg[6:0]), $past(serIn)})
    else $error("Shift register did not move on rising edge");

  AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (reset)
    state == LSD_RESULT && shiftRise && bitCnt == 3'h0 |=> sreg == $past(sreg))
    else $error("First readout edge moved the status word");

  AST_SOUT_FALL: assert property (@(posedge clk) disable iff (reset)
    serial_out != $past(serial_out) |-> $past(shiftFall))
    else $error("Serial output changed without falling edge");

  AST_ENABLE_OFF: assert property (@(posedge clk) disable iff (reset)
    enN |=> channelOn == '0)
    else $error("Outputs on while enable high");

  AST_CHANNEL: assert property (@(posedge clk) disable iff (reset)
    !enN |=> channelOn == $past(storage))
    else $error("Channel does not follow storage bit");

  AST_KEY_ENTRY: assert property (@(posedge clk) disable iff (reset)
    state == LSD_NORMAL && shiftRise && keyMatch |=> state == LSD_DETECT)
    else $error("Key seen but detection not entered");

  AST_STAY_NORMAL: assert property (@(posedge clk) disable iff (reset)
    state == LSD_NORMAL && !(shiftRise && keyMatch) |=> state == LSD_NORMAL)
    else $error("Left normal mode without key");

  AST_CAPTURE: assert property (@(posedge clk) disable iff (reset)
    s_driveEnd |=> sreg == $past(faultSync) && state == LSD_RESULT && bitCnt == 3'h0)
    else $error("Status not captured at end of detection");

  AST_RETURN: assert property (@(posedge clk) disable iff (reset)
    s_lastShift |=> state == LSD_NORMAL)
    else $error("No return to normal after eight status bits");

  AST_DRIVE_WINDOW: assert property (@(posedge clk) disable iff (reset)
    state == LSD_DETECT && !enN ##1 !enN [*2] |-> state == LSD_DRIVE && timer == 8'h01)
    else $error("Detection timer not started on enable low");

  AST_LATCH_PUSH: assert property (@(posedge clk) disable iff (reset)
    latchRise |=> pushReq && latchWord == $past(next_sreg))
    else $error("Latch edge did not queue shift register word");
endmodule

// *** testbench/lsd_host_model.sv ***
/*
  Behavioural host for the LED sink driver pins: shift clock, data, latch, enable.
  Assumes the bench clk; every pin changes just after a rising clk edge.
*/
module lsd_host_model (
  input  wire logic clk,
  input  wire logic serialOut,
  output logic      shiftClkPin,
  output logic      serialIn,
  output logic      latchPin,
  output logic      enableNPin,
  output logic      sampleNow
);
  timeunit 1ns;
  timeprecision 1ps;
  // 150 ns phases keep the shift clock far below its ceiling
  localparam int PHASE = 6;

  // Shift clock stands still and outputs are disabled until used
  initial begin
    shiftClkPin = 1'b0;
    serialIn    = 1'b0;
    latchPin    = 1'b0;
    enableNPin  = 1'b1;
    sampleNow   = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One shift clock; serial output is looked at after the fall, once it settled
  task automatic clockBit(input logic d, input logic watch);
    serialIn <= d;
    idle(PHASE);
    shiftClkPin <= 1'b1;
    idle(PHASE);
    shiftClkPin <= 1'b0;
    serialIn <= ~d; // Data is not held past the clock, so show a changed level
    idle(PHASE);
    sampleNow <= watch;
    idle(1);
    sampleNow <= 1'b0;
  endtask

  // First bit sent ends in the top stage
  task automatic shiftByte(input logic [7:0] v, input logic watch);
    for (int i = 7; i >= 0; i--) begin
      clockBit(v[i], watch);
    end
  endtask

  task automatic latchPulse();
    latchPin <= 1'b1;
    idle(PHASE);
    latchPin <= 1'b0;
    idle(PHASE);
  endtask

  // New enable level is held for one phase before the task returns
  task automatic setEnable(input logic n);
    enableNPin <= n;
    idle(PHASE);
  endtask

  // Key steps sent oldest first on the latch and enable pins
  task automatic sendKey(input logic [4:0] en, input logic [4:0] la);
    for (int i = 4; i >= 0; i--) begin
      enableNPin <= en[i];
      latchPin <= la[i];
      clockBit(1'b0, 1'b0);
    end
    latchPin <= 1'b0;
    enableNPin <= 1'b1;
    idle(PHASE);
  endtask
endmodule

// *** testbench/lsd_driver_tb_top.sv ***
/*
  Self-checking bench for lsd_driver: normal shifting, latching, gating and detection.
  Assumes the host model drives the host pins and the bench sets faultSense; expectations are queued and checked by a monitor.
*/
module lsd_driver_tb_top
  import lsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, reset, shiftClkPin, serialIn, latchPin, enableNPin;
  logic                sampleNow, serialOut, probe;
  logic [CHANNELS-1:0] faultSense, channelOn;
  logic [7:0]          expVal[$];
  string               expName[$];
  int                  err_count = 0;
  int                  checked = 0;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  lsd_driver lsd_driver_i (
    .clk(clk), .reset(reset), .shiftClkPin(shiftClkPin), .serial_in(serialIn),
    .latch_key1_pin(latchPin), .enable_n_key2_pin(enableNPin),
    .faultSense(faultSense), .serial_out(serialOut), .channelOn(channelOn));
  lsd_host_model lsd_host_model_i (
    .clk(clk), .serialOut(serialOut), .shiftClkPin(shiftClkPin), .serialIn(serialIn),
    .latchPin(latchPin), .enableNPin(enableNPin), .sampleNow(sampleNow));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic note(input string name, input logic [7:0] v);
    expName.push_back(name);
    expVal.push_back(v);
  endtask

  // Serial samples come MSB first
  task automatic pushBits(input logic [7:0] v, input string name);
    for (int i = 7; i >= 0; i--) begin
      note(name, {7'h00, v[i]});
    end
  endtask

  task automatic probeCh(input string name, input logic [7:0] v);
    note(name, v);
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask

  // Oldest note against whatever result shows now
  always @(posedge clk) begin
    if (sampleNow || probe) begin
      if (expVal.size() == 0) begin
        err_count++;
        $display("MISMATCH queue expected note seen none");
      end else begin
        check(expName.pop_front(), sampleNow ? {7'h00, serialOut} : channelOn,
              expVal.pop_front());
      end
    end
  end

  // Key, eight ones, drive window of lowClk plus 22 clk, then read the status back
  task automatic detect(input logic [7:0] sense, input int lowClk, input logic [7:0] expStat);
    faultSense <= sense;
    lsd_host_model_i.sendKey(5'b10111, 5'b00010);
    lsd_host_model_i.shiftByte(8'hFF, 1'b0);
    lsd_host_model_i.latchPulse();
    lsd_host_model_i.setEnable(1'b0);
    repeat (14) @(posedge clk);
    probeCh("detect drive", 8'hFF);
    repeat (lowClk) @(posedge clk);
    lsd_host_model_i.setEnable(1'b1);
    pushBits(expStat, "status");
    lsd_host_model_i.shiftByte(8'h00, 1'b1);
  endtask

  task automatic summarize();
    if (expVal.size() != 0) err_count++;
    $display("Counts: checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Cut a hang short; the tests need about 2000 clk
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("MISMATCH watchdog expected done seen timeout");
    summarize();
  end

  initial begin
    int         seed;
    logic [7:0] prev, cur, fault;
    reset = 1'b1;
    probe = 1'b0;
    faultSense = 8'h00;
    seed = $urandom(80459);
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    probeCh("reset channels", 8'h00);
    $display("test reset done");
    // A near miss on the key must leave the device in normal mode
    lsd_host_model_i.sendKey(5'b10111, 5'b00000);
    lsd_host_model_i.setEnable(1'b0);
    prev = 8'h00;
    for (int r = 0; r < 4; r++) begin
      cur = (r == 3) ? 8'h81 : 8'($urandom);
      pushBits({prev[6:0], cur[7]}, "serial out");
      lsd_host_model_i.shiftByte(cur, 1'b1);
      probeCh("held storage", prev);
      lsd_host_model_i.latchPulse();
      repeat (12) @(posedge clk);
      probeCh("channels", cur);
      prev = cur;
    end
    $display("test shift and latch done");
    lsd_host_model_i.setEnable(1'b1);
    probeCh("enable off", 8'h00);
    $display("test enable gating done");
    fault = 8'($urandom);
    detect(fault, 100, fault);
    $display("test detection done");
    // Released before the window ends, status reads all faults
    detect(8'h00, 10, 8'hFF);
    $display("test early release done");
    lsd_host_model_i.shiftByte(8'h5A, 1'b0);
    lsd_host_model_i.latchPulse();
    lsd_host_model_i.setEnable(1'b0);
    repeat (12) @(posedge clk);
    probeCh("resume channels", 8'h5A);
    $display("test resume done");
    summarize();
  end
endmodule
